/* pkg/rif_pkg.sv */
// constants and state types for the clock interrupt status block
package rif_pkg;
  localparam logic [5:0] RIF_CTRL_A_IDX  = 6'h0A; // rate select register
  localparam logic [5:0] RIF_CTRL_B_IDX  = 6'h0B; // enable register
  localparam logic [5:0] RIF_FLAGS_IDX   = 6'h0C; // interrupt_flags
  localparam logic [5:0] RIF_VALID_IDX   = 6'h0D; // power_validity
  localparam int RIF_REQ_BIT       = 7;
  localparam int RIF_PER_BIT       = 6;
  localparam int RIF_ALM_BIT       = 5;
  localparam int RIF_UPD_BIT       = 4;
  localparam int RIF_PWR_VALID_BIT = 7;
  localparam int RIF_SET_BIT       = 7;
  localparam int RIF_PER_EN_BIT    = 6;
  localparam int RIF_ALM_EN_BIT    = 5;
  localparam int RIF_UPD_EN_BIT    = 4;
  localparam int RIF_TAP_W     = 15;
  localparam logic [3:0] RIF_RATE_OFF = 4'h0; // divider output disabled
  localparam logic [7:0] RIF_ZERO8    = 8'h00;
  localparam logic [3:0] RIF_RATE_RST = 4'h0;
  localparam logic [3:0] RIF_LOW_ZERO = 4'h0;

  typedef enum logic [1:0] {RIF_IDLE, RIF_READ, RIF_WRITE} rif_bus_e;
endpackage

/* hw/rif_edge_sel.sv */
// selected divider tap rising-edge detector
`timescale 1ns/1ps
module rif_edge_sel
  import rif_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire logic [RIF_TAP_W-1:0] taps,
  input  wire logic [3:0]           rate_select,
  output logic                      tap_rise
);
  typedef struct packed {
    logic prev;
    logic rise;
  } rif_edge_s;

  rif_edge_s st_reg;
  rif_edge_s st_next;
  logic      sel;

  // pick tap: rate 1..15 selects taps[0..14], 0 disables
  always_comb begin
    sel = 1'b0;
    if (rate_select != RIF_RATE_OFF) begin
      sel = taps[rate_select - 4'h1];
    end
    st_next.prev = sel;
    st_next.rise = sel & ~st_reg.prev;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tap_rise = st_reg.rise;
endmodule

/* hw/rif_irq_flags.sv */
// interrupt flags, enables and power validity behind the multiplexed bus
`timescale 1ns/1ps
// Functional notes
// - combined request is OR of each event flag ANDed with its enable, top bit
// - interrupt request pin low whenever combined request flag is one
// - all flag bits clear after flag register read, and while reset is low
// - periodic flag sets on chosen divider tap edge, regardless of its enable
// - alarm match flag sets when time of day equals alarm time
// - update done flag sets at the end of every update cycle
// - flag register low four bits read zero; writes ignored, register read only
// - power valid flag forced to zero while power sense input is low
// - power valid flag set only by a host read of validity register
// - reset leaves power valid flag unchanged
// - validity register bits six to zero read zero; writes ignored
// - periodic enable gates only the request, flag still sets
// - update enable clears on reset or when update inhibit is set
// - alarm and periodic enables clear on reset
module rif_irq_flags
  import rif_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire logic [7:0]           ad_in,
  output logic [7:0]                ad_out,
  output logic                      ad_oe_n,
  input  wire logic                 addr_latch_strobe,
  input  wire logic                 data_transfer_strobe,
  input  wire logic                 rd_wr_n,
  input  wire logic                 chip_en_n,
  input  wire logic [RIF_TAP_W-1:0] div_taps,
  input  wire logic                 alarm_match,
  input  wire logic                 update_end,
  input  wire logic                 power_sense_input,
  output logic                      irq_n
);
  typedef struct packed {
    logic [5:0] index;
    logic       as_prev;
    logic       dstb_prev;
    logic [7:0] rdata;
    logic       drive;
    logic       clr_pend;
    logic [3:0] rate_select;
    logic       update_inhibit;
    logic       periodic_irq_enable;
    logic       alarm_irq_enable;
    logic       update_irq_enable;
    logic       periodic_flag;
    logic       alarm_match_flag;
    logic       update_done_flag;
  } rif_state_s;

  rif_state_s st_reg;
  rif_state_s st_next;
  logic       pv_reg;
  logic       pv_next;
  logic       tap_rise;
  logic       combined_request_flag;
  logic       as_fall;
  logic       dstb_rise;
  logic       dstb_fall;
  logic       sel;
  rif_bus_e   acc;

  ////////////////////////////////////////////////////////////////////////
  // periodic tap edge
  rif_edge_sel u_edge (
    .clk         (clk),
    .nrst        (nrst),
    .taps        (div_taps),
    .rate_select (st_reg.rate_select),
    .tap_rise    (tap_rise)
  );

  ////////////////////////////////////////////////////////////////////////
  // combined request and pin
  assign combined_request_flag =
      (st_reg.periodic_flag    & st_reg.periodic_irq_enable) |
      (st_reg.alarm_match_flag & st_reg.alarm_irq_enable)    |
      (st_reg.update_done_flag & st_reg.update_irq_enable);
  assign irq_n   = ~combined_request_flag;
  assign ad_out  = st_reg.rdata;
  assign ad_oe_n = ~st_reg.drive;

  // strobe edges and access kind
  // strobes are sampled once per clock, so each level must last one clock
  // the index latches on the falling address strobe, as the host expects
  assign as_fall   = st_reg.as_prev & ~addr_latch_strobe;
  assign dstb_rise = ~st_reg.dstb_prev & data_transfer_strobe;
  assign dstb_fall = st_reg.dstb_prev & ~data_transfer_strobe;
  assign sel       = ~chip_en_n;

  // access kind is taken once, at the rising data strobe
  // chip enable and direction only matter at that edge
  always_comb begin
    acc = RIF_IDLE;
    if (dstb_rise && sel) begin
      acc = rd_wr_n ? RIF_READ : RIF_WRITE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register next state
  always_comb begin
    st_next         = st_reg;
    st_next.as_prev = addr_latch_strobe;
    st_next.dstb_prev = data_transfer_strobe;
    if (as_fall) begin
      st_next.index = ad_in[5:0];
    end
    case (acc)
      RIF_READ: begin
        st_next.drive = 1'b1;
        st_next.rdata = RIF_ZERO8;
        if (st_reg.index == RIF_FLAGS_IDX) begin
          // snapshot before clear; low bits stay zero
          st_next.rdata = {combined_request_flag, st_reg.periodic_flag,
                           st_reg.alarm_match_flag, st_reg.update_done_flag,
                           RIF_LOW_ZERO};
          st_next.clr_pend = 1'b1;
        end else if (st_reg.index == RIF_VALID_IDX) begin
          st_next.rdata[RIF_PWR_VALID_BIT] = pv_reg;
        end else if (st_reg.index == RIF_CTRL_A_IDX) begin
          st_next.rdata[3:0] = st_reg.rate_select;
        end else if (st_reg.index == RIF_CTRL_B_IDX) begin
          st_next.rdata[RIF_SET_BIT] = st_reg.update_inhibit;
          st_next.rdata[RIF_PER_EN_BIT] = st_reg.periodic_irq_enable;
          st_next.rdata[RIF_ALM_EN_BIT] = st_reg.alarm_irq_enable;
          st_next.rdata[RIF_UPD_EN_BIT] = st_reg.update_irq_enable;
        end
      end
      RIF_WRITE: begin
        // flag and validity registers ignore writes
        if (st_reg.index == RIF_CTRL_A_IDX) begin
          st_next.rate_select = ad_in[3:0];
        end else if (st_reg.index == RIF_CTRL_B_IDX) begin
          st_next.update_inhibit      = ad_in[RIF_SET_BIT];
          st_next.periodic_irq_enable = ad_in[RIF_PER_EN_BIT];
          st_next.alarm_irq_enable    = ad_in[RIF_ALM_EN_BIT];
          // setting update inhibit always drops the update enable
          st_next.update_irq_enable   = ad_in[RIF_UPD_EN_BIT] & ~ad_in[RIF_SET_BIT];
        end
      end
      default: begin
      end
    endcase
    // clear after the read completes; new events still set
    // events are applied last, so an event in the clear cycle survives
    if (dstb_fall) begin
      st_next.drive = 1'b0;
      if (st_reg.clr_pend) begin
        st_next.clr_pend         = 1'b0;
        st_next.periodic_flag    = 1'b0;
        st_next.alarm_match_flag = 1'b0;
        st_next.update_done_flag = 1'b0;
      end
    end
    if (tap_rise) begin
      st_next.periodic_flag = 1'b1;
    end
    if (alarm_match) begin
      st_next.alarm_match_flag = 1'b1;
    end
    if (update_end) begin
      st_next.update_done_flag = 1'b1;
    end
  end

  // power valid flag, not reset by nrst
  // unknown after power-up until sense goes low or the register is read
  always_comb begin
    pv_next = pv_reg;
    if (acc == RIF_READ && st_reg.index == RIF_VALID_IDX) begin
      pv_next = 1'b1;
    end
    if (!power_sense_input) begin
      pv_next = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state registers; reset clears flags and enables
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge clk) begin
    pv_reg <= pv_next;
  end
endmodule

/* dv/rif_host_model.sv */
// host model driving the multiplexed index and data strobes
`timescale 1ns/1ps
module rif_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] ad_out,
  output logic [7:0]      ad_in,
  output logic            addr_latch_strobe,
  output logic            data_transfer_strobe,
  output logic            rd_wr_n,
  output logic            chip_en_n
);
  initial {ad_in, addr_latch_strobe, data_transfer_strobe, rd_wr_n, chip_en_n} = 12'h003;
  // one access: index phase, then data phase, address strobe held two clocks, data strobe three
  task automatic acc(input logic [5:0] a, input logic w, c, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clk) #1 ad_in = {2'h0, a};
    addr_latch_strobe = 1'b1;
    repeat (2) @(posedge clk);
    #1 addr_latch_strobe = 1'b0;
    repeat (2) @(posedge clk);
    #1 ad_in = w ? d : ~ad_in; // released bus shows inverse
    rd_wr_n = ~w;
    chip_en_n = c;
    data_transfer_strobe = 1'b1;
    repeat (3) @(posedge clk);
    q = ad_out;
    #1 data_transfer_strobe = 1'b0;
    chip_en_n = 1'b1;
    repeat (3) @(posedge clk);
  endtask
endmodule

/* dv/rif_irq_flags_properties.sv */
// concurrent checks on the flag block ports
`timescale 1ns/1ps
module rif_irq_flags_properties
  import rif_pkg::*;
(
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic [7:0] ad_in,
  input wire logic [7:0] ad_out,
  input wire logic       ad_oe_n,
  input wire logic       addr_latch_strobe,
  input wire logic       data_transfer_strobe,
  input wire logic       rd_wr_n,
  input wire logic       chip_en_n,
  input wire logic       power_sense_input,
  input wire logic       irq_n
);
  logic       as_q;
  logic [5:0] idx;
  wire logic  dstb = data_transfer_strobe;
  // index tracker following the address strobe fall
  always_ff @(posedge clk) begin
    as_q <= addr_latch_strobe;
    if (as_q && !addr_latch_strobe) idx <= ad_in[5:0];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_oe_answer: assert property ($rose(dstb) && !chip_en_n && rd_wr_n |-> ##[1:2] !ad_oe_n)
    else $error("read not answered");
  a_oe_release: assert property (!dstb [*2] |=> ad_oe_n)
    else $error("bus held after strobe");
  a_write_quiet: assert property ($rose(dstb) && !rd_wr_n |=> ad_oe_n [*2])
    else $error("write drove bus");
  a_chip_off: assert property ($rose(dstb) && chip_en_n |=> ad_oe_n [*3])
    else $error("deselected drive");
  a_flag_low: assert property (!ad_oe_n && idx == RIF_FLAGS_IDX |-> ad_out[3:0] == 4'h0)
    else $error("flag low bits set");
  a_valid_low: assert property (!ad_oe_n && idx == RIF_VALID_IDX |-> ad_out[6:0] == 7'h00)
    else $error("validity low bits set");
  a_valid_zero: assert property (!ad_oe_n && idx == RIF_VALID_IDX && !power_sense_input
    && $past(power_sense_input, 4) == 1'b0 |-> !ad_out[7]) else $error("valid while sense low");
  a_irq_clear: assert property ($fell(dstb) && rd_wr_n && idx == RIF_FLAGS_IDX |-> ##[1:3] irq_n)
    else $error("request kept after read");
  c_flag_read: cover property ($fell(dstb) && rd_wr_n && idx == RIF_FLAGS_IDX && !irq_n);
  c_irq: cover property ($fell(irq_n));
  c_valid_set: cover property (!ad_oe_n && idx == RIF_VALID_IDX && ad_out[7]);
endmodule
bind rif_irq_flags rif_irq_flags_properties i_rif_irq_flags_properties (.clk, .nrst, .ad_in,
  .ad_out, .ad_oe_n, .addr_latch_strobe, .data_transfer_strobe, .rd_wr_n, .chip_en_n,
  .power_sense_input, .irq_n);

/* dv/tb_rif_irq_flags.sv */
// self-checking bench for the flag and validity block
`timescale 1ns/1ps
module tb_rif_irq_flags;
  import rif_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, alarm_match = 1'b0, update_end = 1'b0, power_sense_input = 1'b0;
  logic [RIF_TAP_W-1:0] div_taps = '0;
  logic [7:0] ad_in, ad_out, q, e, x;
  logic ad_oe_n, addr_latch_strobe, data_transfer_strobe, rd_wr_n, chip_en_n, irq_n;
  logic [31:0] seed = 32'h9645;
  int failures = 0, checked = 0;
  always #5 clk = ~clk;
  rif_irq_flags i_rif_irq_flags (.clk, .nrst, .ad_in, .ad_out, .ad_oe_n, .addr_latch_strobe,
    .data_transfer_strobe, .rd_wr_n, .chip_en_n, .div_taps, .alarm_match, .update_end,
    .power_sense_input, .irq_n);
  rif_host_model i_rif_host_model (.clk, .ad_out, .ad_in, .addr_latch_strobe,
    .data_transfer_strobe, .rd_wr_n, .chip_en_n);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // expected flag byte from pending events and enables
  function automatic logic [7:0] flags(input logic pa, pu, input logic [7:0] en);
    return {(pa & en[RIF_ALM_EN_BIT]) | (pu & en[RIF_UPD_EN_BIT]), 1'b0, pa, pu, 4'h0};
  endfunction
  task automatic chk(input logic [7:0] got, exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [5:0] a);
    i_rif_host_model.acc(a, 1'b0, 1'b0, 8'h00, q);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    i_rif_host_model.acc(a, 1'b1, 1'b0, d, q);
  endtask
  task automatic rst;
    @(posedge clk) #1 nrst = 1'b0;
    repeat (5) @(posedge clk);
    #1 nrst = 1'b1;
  endtask
  // one-cycle event pulses
  task automatic ev(input logic pa, pu);
    @(posedge clk) #1 {alarm_match, update_end} = {pa, pu};
    @(posedge clk) #1 {alarm_match, update_end} = 2'b00;
    repeat (2) @(posedge clk);
  endtask
  task automatic summarize;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1 nrst = 1'b1;
    rd(RIF_VALID_IDX);
    chk(q, 8'h00);
    #1 power_sense_input = 1'b1;
    rd(RIF_VALID_IDX);
    wr(RIF_VALID_IDX, 8'hFF);
    rd(RIF_VALID_IDX);
    chk(q, 8'h80);
    rst;
    rd(RIF_VALID_IDX);
    chk(q, 8'h80);
    #1 power_sense_input = 1'b0;
    rd(RIF_VALID_IDX);
    chk(q, 8'h00);
    $display("validity test done");
    wr(RIF_CTRL_A_IDX, 8'h01);
    @(posedge clk) #1 div_taps = 15'h0001;
    repeat (4) @(posedge clk);
    #1 div_taps = 15'h0000;
    chk({7'h0, irq_n}, 8'h01);
    rd(RIF_FLAGS_IDX);
    chk(q, 8'h40);
    wr(RIF_CTRL_A_IDX, 8'h00);
    $display("periodic test done");
    for (int i = 0; i < 40; i++) begin
      seed = xs(seed);
      e = seed[7:0] & 8'h70;
      wr(RIF_CTRL_B_IDX, e);
      ev(seed[8], seed[9]);
      x = flags(seed[8], seed[9], e);
      chk({7'h0, irq_n}, {7'h0, ~x[7]});
      wr(RIF_FLAGS_IDX, seed[23:16]);
      rd(RIF_FLAGS_IDX);
      chk(q, x);
      chk({7'h0, irq_n}, 8'h01);
    end
    $display("random test done");
    wr(RIF_CTRL_B_IDX, 8'h70);
    ev(1'b1, 1'b1);
    rst;
    chk({7'h0, irq_n}, 8'h01);
    rd(RIF_CTRL_B_IDX);
    chk(q, 8'h00);
    rd(RIF_FLAGS_IDX);
    chk(q, 8'h00);
    wr(RIF_CTRL_B_IDX, 8'h90);
    rd(RIF_CTRL_B_IDX);
    chk(q, 8'h80);
    i_rif_host_model.acc(RIF_FLAGS_IDX, 1'b0, 1'b1, 8'h00, q);
    $display("reset test done");
    summarize;
  end
  // watchdog against a hung access
  initial begin
    #400000;
    failures++;
    summarize;
  end
endmodule
